// ===== hdl/clock_ctrl_pkg.sv
// Constants, register layout and types shared by the system clock control block.
// Assumes every oscillator, PLL and timer clock reaches this logic as a one-cycle
// tick that is synchronous to core_clk.
package clock_ctrl_pkg;

    // Register byte addresses
    localparam logic [31:0] MISC_CLOCK_SETTINGS_ADDR = 32'h40028000;
    localparam logic [31:0] CLOCK_DIVIDERS_ADDR = 32'h40028004;
    localparam logic [31:0] USER_CLOCK_GATING_ADDR = 32'h40028014;
    localparam logic [31:0] CLOCKING_STATUS_ADDR = 32'h40028018;

    // Reset values
    localparam logic [15:0] MISC_CLOCK_SETTINGS_RST = 16'h0041;
    localparam logic [15:0] CLOCK_DIVIDERS_RST = 16'h0200;
    localparam logic [15:0] USER_CLOCK_GATING_RST = 16'h0040;
    localparam logic [15:0] CLOCKING_STATUS_RST = 16'h0003;

    // Writable bits of each register; all others read as zero except bit 6 of user_clock_gating, forced to one
    localparam logic [15:0] MISC_CLOCK_SETTINGS_MASK = 16'hEFF3;
    localparam logic [15:0] CLOCK_DIVIDERS_MASK = 16'h0707;
    localparam logic [15:0] USER_CLOCK_GATING_MASK = 16'h0060;
    localparam logic [15:0] GATING_FORCED_ONE = 16'h0040;

    // Field positions in misc_clock_settings
    localparam int CRYSTAL_IRQ_EN_BIT = 15;
    localparam int USER_PLL_IRQ_EN_BIT = 14;
    localparam int SYSTEM_PLL_IRQ_EN_BIT = 13;
    localparam int PLL_SOURCE_SEL_BIT = 11;
    localparam int CLOCK_OUT_SEL_LSB = 4;
    localparam int SYS_CLOCK_SEL_LSB = 0;

    // Field positions in clock_dividers and user_clock_gating
    localparam int PERIPH_DIV_SEL_LSB = 8;
    localparam int BUS_DIV_SEL_LSB = 0;
    localparam int UART_CLOCK_OFF_BIT = 5;

    // Field positions in clocking_status
    localparam int SYSTEM_PLL_LOCKED_BIT = 0;
    localparam int USER_PLL_LOCKED_BIT = 1;
    localparam int SYSTEM_PLL_EVENT_BIT = 2;
    localparam int USER_PLL_EVENT_BIT = 3;
    localparam int CRYSTAL_OK_BIT = 12;
    localparam int CRYSTAL_OK_EVENT_BIT = 13;
    localparam int CRYSTAL_FAIL_EVENT_BIT = 14;
    localparam logic [15:0] STATUS_W1C_MASK = 16'h600C;

    // Divider codes
    localparam logic [2:0] PERIPH_DIV_MIN_CODE = 3'h2;

    // System clock sources
    typedef enum logic [1:0] {
        SRC_FAST_OSC = 2'b00,
        SRC_SYSTEM_PLL = 2'b01,
        SRC_USER_PLL = 2'b10,
        SRC_EXT_CLOCK = 2'b11
    } sys_src_t;

    // Clock out selections; other codes hold the pin
    localparam logic [3:0] CLOCK_OUT_SEL_ROOT = 4'h0;
    localparam logic [3:0] CLOCK_OUT_SEL_SLOW_OSC = 4'h1;
    localparam logic [3:0] CLOCK_OUT_SEL_FAST_OSC = 4'h2;
    localparam logic [3:0] CLOCK_OUT_SEL_CORE = 4'h4;
    localparam logic [3:0] CLOCK_OUT_SEL_PERIPH = 4'h5;
    localparam logic [3:0] CLOCK_OUT_SEL_TIMER0 = 4'hB;
    localparam logic [3:0] CLOCK_OUT_SEL_WAKEUP = 4'hE - 4'h2;
    localparam logic [3:0] CLOCK_OUT_SEL_CRYSTAL = 4'hE;

    // Source clock ticks, one cycle per source edge
    typedef struct packed {
        logic slow_internal_osc;
        logic fast_internal_osc;
        logic crystal_osc;
        logic system_pll;
        logic user_pll;
        logic timer0;
        logic wakeup_timer;
    } src_ticks_t;

    // Terminal count of a power-of-two divider: divide by 2**code
    function automatic logic [6:0] div_term(input logic [2:0] code);
        div_term = 7'((8'h01 << code) - 8'h01);
    endfunction

endpackage

// ===== hdl/pow2_clock_divider.sv
// Power-of-two divider of the root clock tick stream.
// Assumes root_tick is a one-cycle pulse per root clock edge, synchronous to core_clk.
`timescale 1ns/10ps
module pow2_clock_divider
    import clock_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Control
    input wire logic [2:0] div_code,
    input wire logic [2:0] reset_code,
    input wire logic root_tick,
    // Result
    output logic div_tick
);

    logic [6:0] count;
    logic [2:0] active_code;

    // New codes are adopted only at a period boundary so no runt period appears
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 7'h00;
            active_code <= 3'h0;
            div_tick <= 1'b0;
        end else if (clk_en) begin
            div_tick <= 1'b0;
            if (root_tick) begin
                if (count >= div_term(active_code)) begin // R19
                    count <= 7'h00;
                    div_tick <= 1'b1;
                    active_code <= div_code; // R19
                end else begin
                    count <= count + 7'h01;
                end
            end
        end
    end

    // reset_code is only a hint of the power-up setting; the first boundary loads div_code
    logic unused_reset_code;
    assign unused_reset_code = ^reset_code;

endmodule

// ===== hdl/system_clock_control.sv
// System clock source selection, dividers, clock output and clock events.
// Assumes all source clocks but the external pin arrive as core_clk-synchronous ticks and that the
// register port is driven synchronously by the core.
//
// Contract
// R01 - PLL reference resets to fast internal oscillator
// R02 - Root clock defaults to system PLL
// R03 - Derive root, bus, peripheral and analog clocks
// R04 - Analog clock follows peripheral clock output
// R05 - Software keeps peripheral divider at 010b
// R06 - Power-up runs from system PLL unaided
// R07 - Bus clock divides by power of two
// R08 - Software configures pin before selecting it
// R09 - Software checks crystal, moves to oscillator
// R10 - Software waits for lock before PLL
// R11 - Crystal change interrupts when enabled
// R12 - User PLL interrupt gated by enable
// R13 - System PLL interrupt gated by enable
// R14 - Bit 11 selects PLL reference
// R15 - Clock out field routes clock to pin
// R16 - Select field picks root clock source
// R17 - Peripheral divider divides by 4 to 128
// R18 - Bus divider codes divide 1 to 128
// R19 - Source and divider changes stay glitch-free
`timescale 1ns/10ps
module system_clock_control
    import clock_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Source clocks and status from the analog side
    input wire src_ticks_t src_ticks,
    input wire logic ext_clock_pin,
    input wire logic system_pll_locked,
    input wire logic user_pll_locked,
    input wire logic crystal_ok,
    // Derived clocks as ticks
    output logic root_sys_clock_tick,
    output logic bus_clock_tick,
    output logic periph_clock_tick,
    output logic analog_clock_tick,
    // Controls to the analog side and pins
    output logic pll_source_sel,
    output logic clock_out_pin,
    output logic uart_clock_off,
    // Interrupts to the core
    output logic crystal_irq,
    output logic user_pll_irq,
    output logic system_pll_irq
);

    logic [15:0] misc_clock_cfg_reg;
    logic [15:0] clock_div_reg;
    logic [15:0] clock_gate_reg;
    logic [15:0] clock_status_reg;
    logic ext_pin_last;
    logic ext_tick;
    logic system_pll_lock_last;
    logic user_pll_lock_last;
    logic crystal_last;
    sys_src_t sys_clock_sel;
    logic [2:0] bus_div_sel;
    logic [2:0] periph_div_sel;
    logic [3:0] clock_out_sel;
    logic next_root_tick;
    logic next_clock_out_tick;
    logic wr_misc;
    logic wr_div;
    logic wr_gate;
    logic wr_status;

    // Address decode
    assign wr_misc = reg_wr && (reg_addr == MISC_CLOCK_SETTINGS_ADDR);
    assign wr_div = reg_wr && (reg_addr == CLOCK_DIVIDERS_ADDR);
    assign wr_gate = reg_wr && (reg_addr == USER_CLOCK_GATING_ADDR);
    assign wr_status = reg_wr && (reg_addr == CLOCKING_STATUS_ADDR);

    // Field extraction
    assign sys_clock_sel = sys_src_t'(misc_clock_cfg_reg[SYS_CLOCK_SEL_LSB +: 2]);
    assign clock_out_sel = misc_clock_cfg_reg[CLOCK_OUT_SEL_LSB +: 4];
    assign bus_div_sel = clock_div_reg[BUS_DIV_SEL_LSB +: 3];
    // Reserved peripheral codes are clamped so the analog clock never runs too fast
    assign periph_div_sel = (clock_div_reg[PERIPH_DIV_SEL_LSB +: 3] < PERIPH_DIV_MIN_CODE) ?
        PERIPH_DIV_MIN_CODE : clock_div_reg[PERIPH_DIV_SEL_LSB +: 3];

    // Configuration registers; reset gives system PLL root and oscillator reference
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            misc_clock_cfg_reg <= MISC_CLOCK_SETTINGS_RST; // R01 R02 R06 R14
            clock_div_reg <= CLOCK_DIVIDERS_RST;
            clock_gate_reg <= USER_CLOCK_GATING_RST;
        end else if (clk_en) begin
            if (wr_misc) begin
                misc_clock_cfg_reg <= reg_wdata & MISC_CLOCK_SETTINGS_MASK;
            end
            if (wr_div) begin
                clock_div_reg <= reg_wdata & CLOCK_DIVIDERS_MASK;
            end
            if (wr_gate) begin
                clock_gate_reg <= (reg_wdata & USER_CLOCK_GATING_MASK) | GATING_FORCED_ONE;
            end
        end
    end

    // External pin edge detect; the pin is already synchronous to core_clk
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_pin_last <= 1'b0;
        end else if (clk_en) begin
            ext_pin_last <= ext_clock_pin;
        end
    end
    assign ext_tick = ext_clock_pin && !ext_pin_last;

    // Root source mux; ticks are whole pulses so a switch cannot cut one short
    always_comb begin
        case (sys_clock_sel)
            SRC_FAST_OSC: next_root_tick = src_ticks.fast_internal_osc; // R16
            SRC_SYSTEM_PLL: next_root_tick = src_ticks.system_pll; // R02 R16
            SRC_USER_PLL: next_root_tick = src_ticks.user_pll; // R16
            SRC_EXT_CLOCK: next_root_tick = ext_tick; // R16
            default: next_root_tick = 1'b0;
        endcase
    end

    // Registered root tick
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            root_sys_clock_tick <= 1'b0;
        end else if (clk_en) begin
            root_sys_clock_tick <= next_root_tick; // R03 R19
        end
    end

    // Bus clock divider
    pow2_clock_divider bus_divider (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .div_code(bus_div_sel), // R07 R18
        .reset_code(CLOCK_DIVIDERS_RST[BUS_DIV_SEL_LSB +: 3]),
        .root_tick(root_sys_clock_tick),
        .div_tick(bus_clock_tick)
    );

    // Peripheral clock divider
    pow2_clock_divider periph_divider (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .div_code(periph_div_sel), // R17
        .reset_code(CLOCK_DIVIDERS_RST[PERIPH_DIV_SEL_LSB +: 3]),
        .root_tick(root_sys_clock_tick),
        .div_tick(periph_clock_tick)
    );

    // Analog clock is a registered copy of the peripheral clock
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            analog_clock_tick <= 1'b0;
        end else if (clk_en) begin
            analog_clock_tick <= periph_clock_tick; // R04 R03
        end
    end

    // Clock out source select; reserved codes hold the pin still
    always_comb begin
        case (clock_out_sel)
            CLOCK_OUT_SEL_ROOT: next_clock_out_tick = root_sys_clock_tick; // R15
            CLOCK_OUT_SEL_SLOW_OSC: next_clock_out_tick = src_ticks.slow_internal_osc; // R15
            CLOCK_OUT_SEL_FAST_OSC: next_clock_out_tick = src_ticks.fast_internal_osc; // R15
            CLOCK_OUT_SEL_CORE: next_clock_out_tick = bus_clock_tick; // R15
            CLOCK_OUT_SEL_PERIPH: next_clock_out_tick = periph_clock_tick; // R15
            CLOCK_OUT_SEL_TIMER0: next_clock_out_tick = src_ticks.timer0; // R15
            CLOCK_OUT_SEL_WAKEUP: next_clock_out_tick = src_ticks.wakeup_timer; // R15
            CLOCK_OUT_SEL_CRYSTAL: next_clock_out_tick = src_ticks.crystal_osc; // R15
            default: next_clock_out_tick = 1'b0;
        endcase
    end

    // Pin toggles per selected edge, so it is a clean square at half the tick rate
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clock_out_pin <= 1'b0;
        end else if (clk_en && next_clock_out_tick) begin
            clock_out_pin <= !clock_out_pin; // R19
        end
    end

    // Control outputs to the analog side and peripherals
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pll_source_sel <= 1'b0; // R01
            uart_clock_off <= 1'b0;
        end else if (clk_en) begin
            pll_source_sel <= misc_clock_cfg_reg[PLL_SOURCE_SEL_BIT]; // R14
            uart_clock_off <= clock_gate_reg[UART_CLOCK_OFF_BIT];
        end
    end

    // Previous lock and crystal levels for change detection
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            system_pll_lock_last <= 1'b1;
            user_pll_lock_last <= 1'b1;
            crystal_last <= 1'b0;
        end else if (clk_en) begin
            system_pll_lock_last <= system_pll_locked;
            user_pll_lock_last <= user_pll_locked;
            crystal_last <= crystal_ok;
        end
    end

    // Status: live levels plus sticky events; a new event beats a same-cycle clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clock_status_reg <= CLOCKING_STATUS_RST;
        end else if (clk_en) begin
            clock_status_reg[SYSTEM_PLL_LOCKED_BIT] <= system_pll_locked; // R10
            clock_status_reg[USER_PLL_LOCKED_BIT] <= user_pll_locked;
            clock_status_reg[CRYSTAL_OK_BIT] <= crystal_ok; // R09
            clock_status_reg[SYSTEM_PLL_EVENT_BIT] <= (system_pll_locked != system_pll_lock_last) ||
                (clock_status_reg[SYSTEM_PLL_EVENT_BIT] && !(wr_status && reg_wdata[SYSTEM_PLL_EVENT_BIT]));
            clock_status_reg[USER_PLL_EVENT_BIT] <= (user_pll_locked != user_pll_lock_last) ||
                (clock_status_reg[USER_PLL_EVENT_BIT] && !(wr_status && reg_wdata[USER_PLL_EVENT_BIT]));
            clock_status_reg[CRYSTAL_OK_EVENT_BIT] <= (crystal_ok && !crystal_last) ||
                (clock_status_reg[CRYSTAL_OK_EVENT_BIT] && !(wr_status && reg_wdata[CRYSTAL_OK_EVENT_BIT]));
            clock_status_reg[CRYSTAL_FAIL_EVENT_BIT] <= (!crystal_ok && crystal_last) ||
                (clock_status_reg[CRYSTAL_FAIL_EVENT_BIT] && !(wr_status && reg_wdata[CRYSTAL_FAIL_EVENT_BIT]));
            clock_status_reg[11:4] <= 8'h00;
            clock_status_reg[15] <= 1'b0;
        end
    end

    // Interrupt levels follow sticky events only while enabled
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            crystal_irq <= 1'b0;
            user_pll_irq <= 1'b0;
            system_pll_irq <= 1'b0;
        end else if (clk_en) begin
            crystal_irq <= misc_clock_cfg_reg[CRYSTAL_IRQ_EN_BIT] &&
                (clock_status_reg[CRYSTAL_OK_EVENT_BIT] || clock_status_reg[CRYSTAL_FAIL_EVENT_BIT]); // R11
            user_pll_irq <= misc_clock_cfg_reg[USER_PLL_IRQ_EN_BIT] && clock_status_reg[USER_PLL_EVENT_BIT]; // R12
            system_pll_irq <= misc_clock_cfg_reg[SYSTEM_PLL_IRQ_EN_BIT] &&
                clock_status_reg[SYSTEM_PLL_EVENT_BIT]; // R13
        end
    end

    // Read data register; unmapped addresses return zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            if (!reg_rd) begin
                reg_rdata <= 16'h0000;
            end else if (reg_addr == MISC_CLOCK_SETTINGS_ADDR) begin
                reg_rdata <= misc_clock_cfg_reg;
            end else if (reg_addr == CLOCK_DIVIDERS_ADDR) begin
                reg_rdata <= clock_div_reg;
            end else if (reg_addr == USER_CLOCK_GATING_ADDR) begin
                reg_rdata <= clock_gate_reg;
            end else if (reg_addr == CLOCKING_STATUS_ADDR) begin
                reg_rdata <= clock_status_reg;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

endmodule

// ===== verification/system_clock_control_properties.sv
// Checker for the system clock control block: timing relations seen at its ports.
// Assumes binding into system_clock_control and clk_en held high while ticks flow.
`timescale 1ns/10ps
module system_clock_control_properties
    import clock_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // Clocks
    input wire src_ticks_t src_ticks,
    input wire logic root_sys_clock_tick,
    input wire logic bus_clock_tick,
    input wire logic periph_clock_tick,
    input wire logic analog_clock_tick,
    // Controls and interrupts
    input wire logic pll_source_sel,
    input wire logic crystal_irq,
    input wire logic user_pll_irq,
    input wire logic system_pll_irq
);
    logic [15:0] misc_copy;
    logic misc_wr;
    logic mapped;
    logic sel_tick;

    // Decoded accesses
    assign misc_wr = clk_en && reg_wr && reg_addr == MISC_CLOCK_SETTINGS_ADDR;
    assign mapped = reg_addr inside {MISC_CLOCK_SETTINGS_ADDR, CLOCK_DIVIDERS_ADDR,
        USER_CLOCK_GATING_ADDR, CLOCKING_STATUS_ADDR};

    // Shadow of the settings register, so enables and selects can be judged
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            misc_copy <= MISC_CLOCK_SETTINGS_RST;
        end else if (misc_wr) begin
            misc_copy <= reg_wdata & MISC_CLOCK_SETTINGS_MASK;
        end
    end

    // Tick of the selected source; the pin input is edge-detected inside, so the bench judges it
    always_comb begin
        case (misc_copy[1:0])
            2'b00: sel_tick = src_ticks.fast_internal_osc;
            2'b01: sel_tick = src_ticks.system_pll;
            default: sel_tick = src_ticks.user_pll;
        endcase
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence ref_write;
        misc_wr ##1 clk_en;
    endsequence

    property irq_gated(logic en, logic irq);
        $past(clk_en) && !$past(en) |-> !irq;
    endproperty

    a_pll_ref_follows: assert property (ref_write |=> pll_source_sel == $past(reg_wdata[11], 2))
        else $error("pll reference select does not follow the written bit");
    a_crystal_irq_gate: assert property (irq_gated(misc_copy[15], crystal_irq))
        else $error("crystal interrupt while disabled");
    a_user_irq_gate: assert property (irq_gated(misc_copy[14], user_pll_irq))
        else $error("user pll interrupt while disabled");
    a_sys_irq_gate: assert property (irq_gated(misc_copy[13], system_pll_irq))
        else $error("system pll interrupt while disabled");
    a_root_follows_sel: assert property (clk_en && misc_copy[1:0] != 2'b11 |=>
        root_sys_clock_tick == $past(sel_tick))
        else $error("root tick does not follow the selected source");
    a_analog_follows_periph: assert property (clk_en |=> analog_clock_tick == $past(periph_clock_tick))
        else $error("analog tick does not follow peripheral tick");
    a_bus_after_root: assert property (bus_clock_tick && $past(clk_en) |-> $past(root_sys_clock_tick))
        else $error("bus tick without a root tick");
    a_periph_spacing: assert property (clk_en && periph_clock_tick |=> !periph_clock_tick [*3])
        else $error("peripheral ticks closer than divide by four");
    a_misc_readback: assert property (clk_en && reg_rd && reg_addr == MISC_CLOCK_SETTINGS_ADDR |=>
        reg_rdata == $past(misc_copy))
        else $error("settings register read back wrong");
    a_unmapped_zero: assert property (clk_en && reg_rd && !mapped |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule

bind system_clock_control system_clock_control_properties i_system_clock_control_properties (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .src_ticks(src_ticks),
    .root_sys_clock_tick(root_sys_clock_tick), .bus_clock_tick(bus_clock_tick),
    .periph_clock_tick(periph_clock_tick), .analog_clock_tick(analog_clock_tick),
    .pll_source_sel(pll_source_sel), .crystal_irq(crystal_irq), .user_pll_irq(user_pll_irq),
    .system_pll_irq(system_pll_irq));

// ===== verification/testbench.sv
// Self-checking bench for the system clock control block.
// Assumes the checker is bound from its own file; source clocks are driven as one-cycle ticks.
`timescale 1ns/10ps
`define CHECK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected at %0t: %s", $time, msg); end end
module testbench;
    import clock_ctrl_pkg::*;
    logic core_clk, rst_b, clk_en, reg_wr, reg_rd, ext_clock_pin;
    logic system_pll_locked, user_pll_locked, crystal_ok, pin_last;
    logic [31:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    src_ticks_t src_ticks;
    logic root_sys_clock_tick, bus_clock_tick, periph_clock_tick, analog_clock_tick;
    logic pll_source_sel, clock_out_pin, uart_clock_off, crystal_irq, user_pll_irq, system_pll_irq;
    int miscompares = 0, total_checks = 0, cycles = 0;
    int n_root, n_bus, n_per, n_ana, n_pin;
    // Clock out codes, the tick bit that feeds each, toggles expected from four ticks
    int out_code [9] = '{0, 1, 2, 4, 5, 11, 12, 14, 3};
    int out_src [9] = '{3, 6, 5, 3, 3, 1, 0, 4, 3};
    int out_exp [9] = '{4, 4, 4, 4, 1, 4, 4, 4, 0};

    system_clock_control i_system_clock_control (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .src_ticks(src_ticks), .ext_clock_pin(ext_clock_pin), .system_pll_locked(system_pll_locked),
        .user_pll_locked(user_pll_locked), .crystal_ok(crystal_ok), .root_sys_clock_tick(root_sys_clock_tick),
        .bus_clock_tick(bus_clock_tick), .periph_clock_tick(periph_clock_tick),
        .analog_clock_tick(analog_clock_tick), .pll_source_sel(pll_source_sel), .clock_out_pin(clock_out_pin),
        .uart_clock_off(uart_clock_off), .crystal_irq(crystal_irq), .user_pll_irq(user_pll_irq),
        .system_pll_irq(system_pll_irq));

    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    // Window counters and the hang limit; a full run needs well under 10000 cycles
    always @(negedge core_clk) begin
        n_root += int'(root_sys_clock_tick);
        n_bus += int'(bus_clock_tick);
        n_per += int'(periph_clock_tick);
        n_ana += int'(analog_clock_tick);
        n_pin += int'(clock_out_pin !== pin_last);
        pin_last = clock_out_pin;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test;
        end
    end

    // Inputs always move 1 ns after the edge, never on it
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask

    // Read data is valid in the cycle after the taking edge
    task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp, input string msg);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        `CHECK(reg_rdata, exp, msg)
        cyc(1);
    endtask

    task automatic pulse(input int b);
        src_ticks[b] = 1'b1;
        cyc(1);
        src_ticks = '0;
        cyc(1);
    endtask

    task automatic t_regs;
        rd_chk(MISC_CLOCK_SETTINGS_ADDR, 16'h0041, "settings reset");
        rd_chk(CLOCK_DIVIDERS_ADDR, 16'h0200, "dividers reset");
        rd_chk(USER_CLOCK_GATING_ADDR, 16'h0040, "gating reset");
        rd_chk(CLOCKING_STATUS_ADDR, 16'h0003, "status reset");
        rd_chk(32'h40028008, 16'h0000, "unmapped read");
        `CHECK(pll_source_sel, 1'b0, "pll reference after reset")
        wr(MISC_CLOCK_SETTINGS_ADDR, 16'hFFFF);
        rd_chk(MISC_CLOCK_SETTINGS_ADDR, 16'hEFF3, "settings mask");
        `CHECK(pll_source_sel, 1'b1, "pll reference crystal")
        wr(CLOCK_DIVIDERS_ADDR, 16'hFFFF);
        clk_en = 1'b0;
        wr(CLOCK_DIVIDERS_ADDR, '0);
        clk_en = 1'b1;
        rd_chk(CLOCK_DIVIDERS_ADDR, 16'h0707, "dividers mask");
        wr(USER_CLOCK_GATING_ADDR, 16'h0020);
        rd_chk(USER_CLOCK_GATING_ADDR, 16'h0060, "gating forced bit");
        `CHECK(uart_clock_off, 1'b1, "uart clock gate")
        wr(MISC_CLOCK_SETTINGS_ADDR, 16'h0041);
        wr(CLOCK_DIVIDERS_ADDR, 16'h0200);
        cyc(2);
        `CHECK(pll_source_sel, 1'b0, "pll reference back")
        $display("register test done");
    endtask

    task automatic t_root_sel;
        for (int s = 0; s < 4; s++) begin
            wr(MISC_CLOCK_SETTINGS_ADDR, 16'h0040 | 16'(s));
            cyc(2);
            n_root = 0;
            pulse(5);
            pulse(3);
            pulse(2);
            ext_clock_pin = 1'b1;
            cyc(2);
            ext_clock_pin = 1'b0;
            cyc(3);
            `CHECK(n_root, 1, "root ticks from selected source")
        end
        wr(MISC_CLOCK_SETTINGS_ADDR, 16'h0041);
        $display("source select test done");
    endtask

    task automatic t_clock_out;
        for (int i = 0; i < 9; i++) begin
            wr(MISC_CLOCK_SETTINGS_ADDR, 16'h0001 | 16'(out_code[i] << 4));
            cyc(2);
            n_pin = 0;
            repeat (4) pulse(out_src[i]);
            cyc(4);
            `CHECK(n_pin, out_exp[i], "clock out toggles")
        end
        wr(MISC_CLOCK_SETTINGS_ADDR, 16'h0041);
        $display("clock out test done");
    endtask

    // Window of 256 root ticks holds whole periods, so counts are exact whatever the phase
    task automatic t_dividers;
        for (int c = 0; c < 8; c++) begin
            wr(CLOCK_DIVIDERS_ADDR, {5'h00, 3'(c), 5'h00, 3'(c)});
            repeat (128) pulse(3);
            n_bus = 0;
            n_per = 0;
            n_ana = 0;
            repeat (256) pulse(3);
            `CHECK(n_bus, 256 >> c, "bus ticks")
            `CHECK(n_per, 256 >> (c < 2 ? 2 : c), "peripheral ticks")
            `CHECK(n_ana, n_per, "analog ticks")
        end
        wr(CLOCK_DIVIDERS_ADDR, 16'h0200);
        $display("divider test done");
    endtask

    task automatic t_irq;
        wr(MISC_CLOCK_SETTINGS_ADDR, 16'h8041);
        crystal_ok = 1'b1;
        cyc(4);
        `CHECK(crystal_irq, 1'b1, "crystal ok interrupt")
        rd_chk(CLOCKING_STATUS_ADDR, 16'h3003, "crystal ok event");
        wr(CLOCKING_STATUS_ADDR, 16'h2000);
        cyc(2);
        `CHECK(crystal_irq, 1'b0, "crystal interrupt cleared")
        crystal_ok = 1'b0;
        cyc(4);
        `CHECK(crystal_irq, 1'b1, "crystal not ok interrupt")
        wr(MISC_CLOCK_SETTINGS_ADDR, 16'h0041);
        cyc(2);
        `CHECK(crystal_irq, 1'b0, "crystal interrupt disabled")
        for (int k = 0; k < 2; k++) begin
            if (k == 0) user_pll_locked = 1'b0;
            else system_pll_locked = 1'b0;
            cyc(4);
            `CHECK({user_pll_irq, system_pll_irq}, 2'b00, "pll interrupts disabled")
            wr(MISC_CLOCK_SETTINGS_ADDR, k == 0 ? 16'h4041 : 16'h2041);
            cyc(2);
            `CHECK({user_pll_irq, system_pll_irq}, k == 0 ? 2'b10 : 2'b01, "pll interrupt")
            wr(CLOCKING_STATUS_ADDR, 16'h000C);
            cyc(2);
            `CHECK({user_pll_irq, system_pll_irq}, 2'b00, "pll interrupt cleared")
            wr(MISC_CLOCK_SETTINGS_ADDR, 16'h0041);
        end
        $display("interrupt test done");
    endtask

    task automatic stop_test;
        $display("checks %0d, miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        reg_addr = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = '0;
        src_ticks = '0;
        ext_clock_pin = 1'b0;
        system_pll_locked = 1'b1;
        user_pll_locked = 1'b1;
        crystal_ok = 1'b0;
        pin_last = 1'b0;
        cyc(3);
        rst_b = 1'b1;
        t_regs;
        t_root_sel;
        t_clock_out;
        t_dividers;
        t_irq;
        stop_test;
    end
endmodule
